// file: calibration_memory_access.sv
// Notes on behaviour
// - read-only data and status register at offset 68H
// - every data/status read starts a one millisecond memory access
// - completed read places addressed byte on bits 15 to 8
// - request taken at once; read byte valid 2.5 ms later
// - bit 0 set once the read byte is valid
// - read-complete clears on new read start and on hardware reset
// - bits 7..2 unused, bit 1 write busy, bit 0 read complete
// - memory writes need the enable code, a factory operation
// - a memory write takes about five milliseconds
// - write-busy set at write start, held until write finishes
// - hardware reset clears write-busy
// - status register read only as 32-bit or 16-bit transfers
// - software or hardware reset clears the whole status register
// - write-only request register at 64H; bit 15 chooses read or write
// - request bits 14..8 address, 7..0 write byte; resets leave it alone
`timescale 1ns/1ps
`default_nettype none
module calibration_memory_access #(
	parameter int ACCESS_CNT = calmem_pkg::ACCESS_CYCLES,
	parameter int READ_CNT   = calmem_pkg::READ_CYCLES,
	parameter int WRITE_CNT  = calmem_pkg::WRITE_CYCLES
) (
	input  wire logic        REF_CLK,
	input  wire logic        SYS_RST,
	input  wire logic        SOFT_RST,
	input  wire logic        WR_EN,
	input  wire logic        RD_EN,
	input  wire logic [11:0] ADDR,
	input  wire logic [3:0]  BYTE_EN,
	input  wire logic [31:0] WR_DATA,
	input  wire logic        WRITE_UNLOCK,
	output logic      [31:0] RD_DATA,
	output logic             ACCESS_BUSY,
	output logic             WRITE_REFUSED
);
	localparam int W = calmem_pkg::CNT_W;

	// ****************************************
	// decode
	// ****************************************
	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = (a[11:2] == o[11:2]);
	endfunction : hit

	logic           req_wr;
	logic           stat_rd;
	calmem_pkg::req_t req;
	calmem_pkg::req_t req_word;
	calmem_pkg::seq_t state;
	calmem_pkg::seq_t next_state;

	// request register strobe, needs both low lanes
	assign req_wr = WR_EN && hit(ADDR, calmem_pkg::ACCESS_REQ_OFFSET)
		&& (BYTE_EN[1:0] == 2'b11);
	// narrower than 16-bit reads are not honoured
	assign stat_rd = RD_EN && hit(ADDR, calmem_pkg::DATA_STATUS_OFFSET)
		&& (BYTE_EN[1:0] == 2'b11);
	assign req = calmem_pkg::req_t'(WR_DATA[15:0]);

	// ****************************************
	// timers
	// ****************************************
	logic         op_load;
	logic [W-1:0] op_value;
	logic         op_busy;
	logic         op_done;
	logic         win_busy;

	calmem_timer #(.W(W)) u_op_timer (
		.clk   (REF_CLK),
		.rst   (SYS_RST),
		.load  (op_load),
		.value (op_value),
		.busy  (op_busy),
		.done  (op_done)
	);

	// each status read arms a one millisecond access window
	calmem_timer #(.W(W)) u_win_timer (
		.clk   (REF_CLK),
		.rst   (SYS_RST),
		.load  (stat_rd),
		.value (W'(ACCESS_CNT)),
		.busy  (win_busy),
		.done  ()
	);

	// ****************************************
	// sequencer
	// ****************************************
	logic start_rd;
	logic start_wr;

	// requests during write-busy or a window are ignored
	assign start_rd = req_wr && req.rd && state == calmem_pkg::SEQ_IDLE
		&& !win_busy;
	// writes only with the enable code present
	assign start_wr = req_wr && !req.rd && WRITE_UNLOCK
		&& state == calmem_pkg::SEQ_IDLE && !win_busy;

	// latencies loaded into the board clock counter
	always_comb begin
		op_load  = start_rd || start_wr;
		op_value = start_rd ? W'(READ_CNT) : W'(WRITE_CNT);
	end

	always_comb begin
		next_state = state;
		case (state)
			calmem_pkg::SEQ_IDLE: begin
				if (start_rd) begin
					next_state = calmem_pkg::SEQ_READ;
				end else if (start_wr) begin
					next_state = calmem_pkg::SEQ_WRITE;
				end
			end
			calmem_pkg::SEQ_READ: begin
				if (op_done) begin
					next_state = calmem_pkg::SEQ_HOLD;
				end
			end
			calmem_pkg::SEQ_WRITE: begin
				if (op_done) begin
					next_state = calmem_pkg::SEQ_IDLE;
				end
			end
			calmem_pkg::SEQ_HOLD: begin
				next_state = calmem_pkg::SEQ_IDLE;
			end
			default: begin
				next_state = calmem_pkg::SEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			state <= calmem_pkg::SEQ_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// request word untouched by either reset
	always_ff @(posedge REF_CLK) begin
		if (req_wr) begin
			req_word <= req;
		end
	end

	// ****************************************
	// memory cells
	// ****************************************
	logic [7:0] mem_rdata;

	// cell updated as the write time runs out
	calmem_store #(.AW(7)) u_store (
		.clk   (REF_CLK),
		.we    (state == calmem_pkg::SEQ_WRITE && op_done),
		.waddr (req_word.addr),
		.wdata (req_word.data),
		.raddr (req_word.addr),
		.rdata (mem_rdata)
	);

	// ****************************************
	// data and status register
	// ****************************************
	logic [7:0] rd_byte;
	logic       rd_done;
	logic       wr_busy;

	always_ff @(posedge REF_CLK) begin
		// either reset zeroes the whole register
		if (SYS_RST || SOFT_RST) begin
			rd_byte <= 8'h00;
			rd_done <= 1'b0;
			wr_busy <= 1'b0;
		end else begin
			// new read start clears read complete
			if (start_rd) begin
				rd_done <= 1'b0;
			// byte lands on 15..8 with flag
			end else if (state == calmem_pkg::SEQ_HOLD) begin
				rd_byte <= mem_rdata;
				rd_done <= 1'b1;
			end
			// busy from write start until finish
			if (start_wr) begin
				wr_busy <= 1'b1;
			end else if (state == calmem_pkg::SEQ_WRITE && op_done) begin
				wr_busy <= 1'b0;
			end
		end
	end

	// read port; bits 7..2 read zero
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			RD_DATA <= 32'h0000_0000;
		end else if (stat_rd) begin
			RD_DATA <= {16'h0000, rd_byte, 6'h00, wr_busy, rd_done};
		end else begin
			RD_DATA <= 32'h0000_0000;
		end
	end

	// busy shows an access window or the read or write latency in progress
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			ACCESS_BUSY   <= 1'b0;
			WRITE_REFUSED <= 1'b0;
		end else begin
			// sequencer state too: the hold step has no timer running
			ACCESS_BUSY   <= op_busy || win_busy || op_load || stat_rd
				|| (state != calmem_pkg::SEQ_IDLE);
			WRITE_REFUSED <= req_wr && !req.rd && !WRITE_UNLOCK;
		end
	end
endmodule : calibration_memory_access
`default_nettype wire

// file: calmem_pkg.sv
package calmem_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [11:0] ACCESS_REQ_OFFSET  = 12'h064;
	localparam logic [11:0] DATA_STATUS_OFFSET = 12'h068;

	// ****************************************
	// field positions
	// ****************************************
	localparam int REQ_READ_BIT     = 15;
	localparam int REQ_ADDR_MSB     = 14;
	localparam int REQ_ADDR_LSB     = 8;
	localparam int REQ_DATA_MSB     = 7;
	localparam int REQ_DATA_LSB     = 0;
	localparam int STAT_DATA_MSB    = 15;
	localparam int STAT_DATA_LSB    = 8;
	localparam int STAT_WBUSY_BIT   = 1;
	localparam int STAT_RDONE_BIT   = 0;
	localparam logic [15:0] STATUS_RESET = 16'h0000;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_PS   = 4000;
	localparam int ACCESS_TIME_US  = 1000;
	localparam int READ_TIME_US    = 2500;
	localparam int WRITE_TIME_US   = 5000;
	// worked in ns: microseconds times 10^6 would overflow a 32-bit int
	localparam int CLK_PERIOD_NS = CLK_PERIOD_PS / 1000;
	localparam int ACCESS_CYCLES = (ACCESS_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int READ_CYCLES   = (READ_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int WRITE_CYCLES  = (WRITE_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int CNT_W = 24;

	// a request word split into its fields
	typedef struct packed {
		logic       rd;
		logic [6:0] addr;
		logic [7:0] data;
	} req_t;

	typedef enum logic [1:0] {
		SEQ_IDLE  = 2'b00,
		SEQ_READ  = 2'b01,
		SEQ_WRITE = 2'b10,
		SEQ_HOLD  = 2'b11
	} seq_t;
endpackage : calmem_pkg

// file: calmem_timer.sv
`timescale 1ns/1ps
`default_nettype none
module calmem_timer #(
	parameter int W = 24
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         load,
	input  wire logic [W-1:0] value,
	output logic              busy,
	output logic              done
);
	logic [W-1:0] count;

	// reload wins over a running count
	always_ff @(posedge clk) begin
		if (rst) begin
			count <= '0;
			done  <= 1'b0;
		end else if (load) begin
			count <= value;
			done  <= 1'b0;
		end else if (count != '0) begin
			count <= count - 1'b1;
			done  <= (count == {{(W-1){1'b0}}, 1'b1});
		end else begin
			done  <= 1'b0;
		end
	end

	assign busy = (count != '0);
endmodule : calmem_timer
`default_nettype wire

// file: calmem_store.sv
`timescale 1ns/1ps
`default_nettype none
module calmem_store #(
	parameter int AW = 7
) (
	input  wire logic          clk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [7:0]    wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [7:0]    rdata
);
	// non-volatile contents: no reset, survives module resets
	logic [7:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk) begin
		rdata <= mem[raddr];
	end
endmodule : calmem_store
`default_nettype wire

// file: calmem_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// checks
// ********
module calmem_asserts #(
	parameter int ACCESS_CNT = 10
) (
	input wire logic        REF_CLK,
	input wire logic        SYS_RST,
	input wire logic        SOFT_RST,
	input wire logic        WR_EN,
	input wire logic        RD_EN,
	input wire logic [11:0] ADDR,
	input wire logic [3:0]  BYTE_EN,
	input wire logic [31:0] WR_DATA,
	input wire logic        WRITE_UNLOCK,
	input wire logic [31:0] RD_DATA,
	input wire logic        ACCESS_BUSY,
	input wire logic        WRITE_REFUSED
);
	logic hit;
	assign hit = WR_EN && ADDR == 12'h064 && BYTE_EN[1:0] == 2'h3;
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (SYS_RST);
	sequence s_poll;
		RD_EN && ADDR == 12'h068 && BYTE_EN[1:0] == 2'h3;
	endsequence
	sequence s_soft;
		SOFT_RST ##2 s_poll;
	endsequence
	a_unused_bits:
		assert property (RD_DATA[7:2] == 6'h00) else $error("unused set");
	a_idle_zero:
		assert property (!$past(RD_EN) |-> RD_DATA == 32'h0)
		else $error("data without read");
	a_refuse_pulse:
		assert property (hit && !WR_DATA[15] && !WRITE_UNLOCK && !ACCESS_BUSY
		|=> WRITE_REFUSED) else $error("no refuse pulse");
	a_refuse_cause:
		assert property (WRITE_REFUSED |-> $past(WR_EN) && !$past(WRITE_UNLOCK))
		else $error("stray refuse");
	a_busy_start:
		assert property (hit && !ACCESS_BUSY && (WR_DATA[15] || WRITE_UNLOCK)
		|=> ACCESS_BUSY) else $error("access not started");
	a_poll_window:
		assert property (s_poll |=> ACCESS_BUSY [*8]) else $error("no window");
	a_soft_clear:
		assert property (s_soft |=> RD_DATA[15:0] == 16'h0)
		else $error("soft reset kept status");
	a_reset_clear:
		assert property ($fell(SYS_RST) |-> RD_DATA == 32'h0 && !ACCESS_BUSY
		&& !WRITE_REFUSED) else $error("reset left state");
endmodule : calmem_asserts
`default_nettype wire

// file: calmem_host.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// host model
// ********
module calmem_host #(
	parameter int AC = 10
) (
	input  wire logic        clk,
	input  wire logic [31:0] rd_data,
	output var  logic        wr_en,
	output var  logic        rd_en,
	output var  logic [11:0] addr,
	output var  logic [3:0]  byte_en,
	output var  logic [31:0] wr_data
);
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 12'hFFF;
		byte_en = 4'hF;
		wr_data = 32'h0;
	end
	task automatic put(input logic [15:0] w);
		@(posedge clk);
		#1;
		wr_en = 1'b1;
		addr = 12'h064;
		wr_data = {16'h0000, w};
		@(posedge clk);
		#1;
		wr_en = 1'b0;
		addr = 12'hFFF;
		wr_data = ~wr_data;
	endtask : put
	// poll, then wait out the access window
	task automatic get(input logic [3:0] be, output logic [31:0] q);
		@(posedge clk);
		#1;
		rd_en = 1'b1;
		addr = 12'h068;
		byte_en = be;
		@(posedge clk);
		#1;
		rd_en = 1'b0;
		addr = 12'hFFF;
		byte_en = 4'hF;
		q = rd_data;
		repeat (AC + 2) @(posedge clk);
	endtask : get
endmodule : calmem_host
`default_nettype wire

// file: tb_calibration_memory_access.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// bench
// ********
module tb_calibration_memory_access;
	localparam int AC = 10;
	localparam int RC = 20;
	localparam int WC = 40;
	logic        REF_CLK;
	logic        SYS_RST;
	logic        SOFT_RST;
	logic        WRITE_UNLOCK;
	logic        WR_EN;
	logic        RD_EN;
	logic [11:0] ADDR;
	logic [3:0]  BYTE_EN;
	logic [31:0] WR_DATA;
	logic [31:0] RD_DATA;
	logic        ACCESS_BUSY;
	logic        WRITE_REFUSED;
	logic [31:0] q;
	int          err_total;
	int          total_checks;
	calibration_memory_access #(.ACCESS_CNT(AC), .READ_CNT(RC),
		.WRITE_CNT(WC)) dut (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
		.SOFT_RST(SOFT_RST), .WR_EN(WR_EN), .RD_EN(RD_EN), .ADDR(ADDR),
		.BYTE_EN(BYTE_EN), .WR_DATA(WR_DATA), .WRITE_UNLOCK(WRITE_UNLOCK),
		.RD_DATA(RD_DATA), .ACCESS_BUSY(ACCESS_BUSY),
		.WRITE_REFUSED(WRITE_REFUSED));
	calmem_host #(.AC(AC)) host (.clk(REF_CLK), .rd_data(RD_DATA),
		.wr_en(WR_EN), .rd_en(RD_EN), .addr(ADDR), .byte_en(BYTE_EN),
		.wr_data(WR_DATA));
	initial begin
		REF_CLK = 1'b0;
		forever #2 REF_CLK = ~REF_CLK;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	// bounded poll until a status bit settles
	task automatic wait_bit(input int b, input logic v);
		host.get(4'hF, q);
		for (int n = 0; q[b] !== v; n++) begin
			if (n > 20) begin
				err_total++;
				$display("CHECK FAILED %0t poll timeout", $time);
				tally_and_finish;
			end
			host.get(4'hF, q);
		end
	endtask : wait_bit
	task automatic t_write_read;
		WRITE_UNLOCK = 1'b1;
		host.put(16'h05AB);
		host.get(4'hF, q);
		chk(q, 32'h0000_0002);
		wait_bit(1, 1'b0);
		chk(q, 32'h0);
		host.put(16'h8500);
		wait_bit(0, 1'b1);
		chk(q, 32'h0000_AB01);
	endtask : t_write_read
	task automatic t_refuse;
		WRITE_UNLOCK = 1'b0;
		host.put(16'h05CD);
		chk({31'h0, WRITE_REFUSED}, 32'h1);
		host.put(16'h8500);
		chk({31'h0, ACCESS_BUSY}, 32'h1);
		host.get(4'hF, q);
		chk({31'h0, q[0]}, 32'h0);
		wait_bit(0, 1'b1);
		chk(q, 32'h0000_AB01);
		host.get(4'h3, q);
		chk(q, 32'h0000_AB01);
		host.get(4'h1, q);
		chk(q, 32'h0);
	endtask : t_refuse
	task automatic t_soft;
		@(posedge REF_CLK);
		#1;
		SOFT_RST = 1'b1;
		@(posedge REF_CLK);
		#1;
		SOFT_RST = 1'b0;
		host.get(4'hF, q);
		chk(q, 32'h0);
	endtask : t_soft
	task automatic t_hw_reset;
		WRITE_UNLOCK = 1'b1;
		host.put(16'h0A11);
		@(posedge REF_CLK);
		#1;
		SYS_RST = 1'b1;
		@(posedge REF_CLK);
		#1;
		SYS_RST = 1'b0;
		host.get(4'hF, q);
		chk(q, 32'h0);
	endtask : t_hw_reset
	initial begin
		SYS_RST = 1'b1;
		SOFT_RST = 1'b0;
		WRITE_UNLOCK = 1'b0;
		err_total = 0;
		total_checks = 0;
		repeat (8) @(posedge REF_CLK);
		#1;
		SYS_RST = 1'b0;
		t_write_read;
		t_refuse;
		t_soft;
		t_hw_reset;
		tally_and_finish;
	end
endmodule : tb_calibration_memory_access
bind calibration_memory_access calmem_asserts #(.ACCESS_CNT(ACCESS_CNT)) chk_u (
	.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .SOFT_RST(SOFT_RST),
	.WR_EN(WR_EN), .RD_EN(RD_EN), .ADDR(ADDR), .BYTE_EN(BYTE_EN),
	.WR_DATA(WR_DATA), .WRITE_UNLOCK(WRITE_UNLOCK), .RD_DATA(RD_DATA),
	.ACCESS_BUSY(ACCESS_BUSY), .WRITE_REFUSED(WRITE_REFUSED));
`default_nettype wire
